// ### src/mdc_dial_ctrl.sv
// backplane registers, phone number store and dial/hang-up control of the modem
`timescale 1ns/1ns
module mdc_dial_ctrl #(
    parameter int unsigned CLK_HZ = mdc_pkg::CLK_HZ,
    parameter int unsigned CARRIER_WAIT_CYC = mdc_pkg::CARRIER_WAIT_S * mdc_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // backplane register window
    input wire logic [3:0] bp_addr_in,
    input wire logic bp_wr_in,
    input wire logic bp_rd_in,
    input wire logic [15:0] bp_wdata_in,
    output logic [15:0] bp_rdata_out,
    // configuration path to the digit store
    input wire logic [3:0] cfg_addr_in,
    input wire logic cfg_wr_in,
    input wire logic [15:0] cfg_wdata_in,
    // line status from the modem front end
    input wire logic carrier_in,
    input wire logic ring_in,
    input wire logic pw_seen_valid_in,
    input wire logic [15:0] pw_seen_in,
    // dialer
    output logic off_hook_out,
    output logic [7:0] digit_out,
    output logic digit_valid_out,
    input wire logic digit_ready_in,
    // line and port configuration
    output logic [3:0] line_char_bits_out,
    output logic [1:0] line_parity_out,
    output logic line_crc_out,
    output logic [1:0] port_parity_out,
    output logic port_crc_out,
    output logic port_tick_out,
    output logic line_tick_out
);
    if (CARRIER_WAIT_CYC < 2) begin : g_bad_wait
        $error("carrier wait must be at least two cycles");
    end

    mdc_pkg::mdc_state_t state_q;
    mdc_pkg::mdc_state_t state_d;
    logic [15:0] cmd_q;
    logic [15:0] port_baud_q;
    logic [15:0] line_baud_q;
    logic [15:0] ptr_q;
    logic [15:0] password_q;
    logic [15:0] last_pw_q;
    logic [15:0] digits_q [mdc_pkg::DIGIT_REGS];
    logic [15:0] bp_rdata_q;
    logic [3:0] err_sticky_q;
    logic [3:0] err_sticky_d;
    logic [3:0] idx_q;
    logic [3:0] idx_d;
    logic sel_q;
    logic sel_d;
    logic orig_q;
    logic orig_d;
    logic dial_prev_q;
    logic carrier_q;
    logic ring_q;
    logic [31:0] wait_cnt_q;

    // decode of the backplane write path
    logic wr_cmd, wr_port_baud, wr_line_baud, wr_ptr, wr_pw;
    assign wr_cmd = bp_wr_in && (bp_addr_in == mdc_pkg::ADDR_CMD);
    assign wr_port_baud = bp_wr_in && (bp_addr_in == mdc_pkg::ADDR_PORT_BAUD);
    assign wr_line_baud = bp_wr_in && (bp_addr_in == mdc_pkg::ADDR_LINE_BAUD);
    assign wr_ptr = bp_wr_in && (bp_addr_in == mdc_pkg::ADDR_DIAL_PTR);
    assign wr_pw = bp_wr_in && (bp_addr_in == mdc_pkg::ADDR_PASSWORD);

    // dial bit edges
    logic dial, dial_rise, dial_fall;
    assign dial = cmd_q[mdc_pkg::CMD_DIAL];
    assign dial_rise = dial && !dial_prev_q;
    assign dial_fall = !dial && dial_prev_q;

    // configuration decoded from the command word
    assign line_parity_out = cmd_q[mdc_pkg::CMD_LPAR_HI:mdc_pkg::CMD_LPAR_LO];
    assign port_parity_out = cmd_q[mdc_pkg::CMD_PPAR_HI:mdc_pkg::CMD_PPAR_LO];
    assign line_crc_out = cmd_q[mdc_pkg::CMD_LINE_CRC];
    assign port_crc_out = cmd_q[mdc_pkg::CMD_PORT_CRC];
    assign line_char_bits_out = (line_parity_out == mdc_pkg::PAR_NONE) ? mdc_pkg::CHAR_BITS_NO_PAR
                                                                        : mdc_pkg::CHAR_BITS_PAR;

    logic port_code_ok, line_code_ok;
    mdc_baud_tick #(.CLK_HZ(CLK_HZ)) u_port_baud (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .code_in(port_baud_q),
        .code_ok_out(port_code_ok),
        .tick_out(port_tick_out)
    );
    mdc_baud_tick #(.CLK_HZ(CLK_HZ)) u_line_baud (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .code_in(line_baud_q),
        .code_ok_out(line_code_ok),
        .tick_out(line_tick_out)
    );

    // digit selection, high byte first, zero byte ends
    logic [3:0] slot;
    logic idx_ok, ptr_ok;
    logic [15:0] cur_word;
    logic [7:0] cur_byte;
    assign slot = idx_q - mdc_pkg::ADDR_DIG_FIRST;
    assign idx_ok = (idx_q >= mdc_pkg::ADDR_DIG_FIRST);
    assign cur_word = idx_ok ? digits_q[slot[2:0]] : mdc_pkg::WORD_ZERO;
    assign cur_byte = sel_q ? cur_word[7:0] : cur_word[15:8];
    // pointer must name a digit register
    assign ptr_ok = (ptr_q >= {12'h000, mdc_pkg::ADDR_DIG_FIRST}) && (ptr_q <= {12'h000, mdc_pkg::ADDR_DIG_LAST});
    assign digit_valid_out = (state_q == mdc_pkg::ST_DIGITS) && dial && idx_ok && (cur_byte != mdc_pkg::BYTE_ZERO);
    assign digit_out = cur_byte;
    assign off_hook_out = (state_q != mdc_pkg::ST_IDLE);

    logic wait_done;
    assign wait_done = (wait_cnt_q == CARRIER_WAIT_CYC - 1);

    // call control
    always_comb begin
        state_d = state_q;
        orig_d = orig_q;
        idx_d = idx_q;
        sel_d = sel_q;
        err_sticky_d = err_sticky_q;
        case (state_q)
            mdc_pkg::ST_IDLE: begin
                // a dial request with carrier present is ignored
                if (dial_rise && !carrier_in) begin
                    state_d = mdc_pkg::ST_DIGITS;
                    orig_d = 1'b1;
                    // dialing starts at the pointed register
                    idx_d = ptr_q[3:0];
                    sel_d = 1'b0;
                    err_sticky_d = 4'h0;
                    err_sticky_d[mdc_pkg::ERR_BAD_PTR] = !ptr_ok;
                end else if (ring_in && !cmd_q[mdc_pkg::CMD_ORIG_ONLY]) begin
                    state_d = mdc_pkg::ST_WAIT;
                    orig_d = 1'b0;
                end
            end
            mdc_pkg::ST_DIGITS: begin
                // cleared dial bit abandons the call
                if (!dial) begin
                    state_d = mdc_pkg::ST_IDLE;
                end else if (!digit_valid_out) begin
                    state_d = mdc_pkg::ST_WAIT;
                end else if (digit_ready_in) begin
                    sel_d = !sel_q;
                    idx_d = sel_q ? idx_q + 4'h1 : idx_q;
                end
            end
            mdc_pkg::ST_WAIT: begin
                if (orig_q && !dial) begin
                    state_d = mdc_pkg::ST_IDLE;
                end else if (carrier_in) begin
                    state_d = mdc_pkg::ST_ONLINE;
                end else if (wait_done) begin
                    state_d = mdc_pkg::ST_IDLE;
                    err_sticky_d[mdc_pkg::ERR_NO_CARRIER] = 1'b1;
                end
            end
            mdc_pkg::ST_ONLINE: begin
                if (!carrier_in) begin
                    state_d = mdc_pkg::ST_IDLE;
                // originated hangs on level, answered on falling edge
                end else if (orig_q ? !dial : dial_fall) begin
                    state_d = mdc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = mdc_pkg::ST_IDLE;
            end
        endcase
    end

    // status mirrors the active configuration and line state
    logic [15:0] status_word, error_word;
    assign status_word = {ring_q, off_hook_out, cmd_q[mdc_pkg::CMD_CFG_HI:1], carrier_q};
    assign error_word = {12'h000, err_sticky_q[3:2], !line_code_ok, !port_code_ok};

    // digit store stays outside the backplane window
    logic [15:0] rd_word;
    assign rd_word = (bp_addr_in == mdc_pkg::ADDR_CMD) ? cmd_q :
                     (bp_addr_in == mdc_pkg::ADDR_STATUS) ? status_word :
                     (bp_addr_in == mdc_pkg::ADDR_PORT_BAUD) ? port_baud_q :
                     (bp_addr_in == mdc_pkg::ADDR_LINE_BAUD) ? line_baud_q :
                     (bp_addr_in == mdc_pkg::ADDR_DIAL_PTR) ? ptr_q :
                     (bp_addr_in == mdc_pkg::ADDR_ERROR) ? error_word :
                     (bp_addr_in == mdc_pkg::ADDR_PASSWORD) ? password_q :
                     (bp_addr_in == mdc_pkg::ADDR_LAST_PW) ? last_pw_q : mdc_pkg::WORD_ZERO;
    assign bp_rdata_out = bp_rdata_q;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_q <= mdc_pkg::CMD_RST;
            port_baud_q <= mdc_pkg::BAUD_RST;
            line_baud_q <= mdc_pkg::BAUD_RST;
            ptr_q <= mdc_pkg::PTR_RST;
            password_q <= mdc_pkg::WORD_ZERO;
            last_pw_q <= mdc_pkg::WORD_ZERO;
            bp_rdata_q <= mdc_pkg::WORD_ZERO;
        end else begin
            if (wr_cmd) cmd_q <= bp_wdata_in;
            if (wr_port_baud) port_baud_q <= bp_wdata_in;
            if (wr_line_baud) line_baud_q <= bp_wdata_in;
            if (wr_ptr) ptr_q <= bp_wdata_in;
            if (wr_pw) password_q <= bp_wdata_in;
            if (pw_seen_valid_in) last_pw_q <= pw_seen_in;
            if (bp_rd_in) bp_rdata_q <= rd_word;
        end
    end

    // digit store, written only over the configuration path
    for (genvar i = 0; i < mdc_pkg::DIGIT_REGS; i++) begin : g_digit
        always_ff @(posedge clk_sys_in or negedge nrst_in) begin
            if (!nrst_in) begin
                digits_q[i] <= mdc_pkg::WORD_ZERO;
            end else if (cfg_wr_in && (cfg_addr_in == mdc_pkg::ADDR_DIG_FIRST + 4'(i))) begin
                digits_q[i] <= cfg_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= mdc_pkg::ST_IDLE;
            orig_q <= 1'b0;
            idx_q <= 4'h0;
            sel_q <= 1'b0;
            err_sticky_q <= 4'h0;
            dial_prev_q <= 1'b0;
            carrier_q <= 1'b0;
            ring_q <= 1'b0;
            wait_cnt_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            orig_q <= orig_d;
            idx_q <= idx_d;
            sel_q <= sel_d;
            err_sticky_q <= err_sticky_d;
            dial_prev_q <= dial;
            carrier_q <= carrier_in;
            ring_q <= ring_in;
            // restarts on every entry to the wait state
            wait_cnt_q <= (state_q == mdc_pkg::ST_WAIT) ? wait_cnt_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    dial_ignore_a:
    assert property (state_q == mdc_pkg::ST_IDLE && dial_rise && carrier_in |=> state_q != mdc_pkg::ST_DIGITS)
        else $error("dial accepted while carrier present");
    hang_orig_a:
    assert property (state_q == mdc_pkg::ST_ONLINE && orig_q && !dial |=> !off_hook_out)
        else $error("originated call did not hang up on cleared dial bit");
    hang_answer_a:
    assert property (state_q == mdc_pkg::ST_ONLINE && !orig_q && carrier_in |->
                     (dial_fall ##1 !off_hook_out) or (!dial_fall ##1 off_hook_out))
        else $error("answered call hang-up not tied to dial falling edge");
    carrier_loss_a:
    assert property (state_q == mdc_pkg::ST_ONLINE && !carrier_in |=> !off_hook_out)
        else $error("no hang-up on carrier loss");
    char_len_a:
    assert property (line_char_bits_out == ((cmd_q[mdc_pkg::CMD_LPAR_HI:mdc_pkg::CMD_LPAR_LO] == mdc_pkg::PAR_NONE)
                     ? mdc_pkg::CHAR_BITS_NO_PAR : mdc_pkg::CHAR_BITS_PAR))
        else $error("line character length does not follow parity");
    baud_code_a:
    assert property (wr_line_baud && bp_wdata_in == mdc_pkg::BAUD_CODE_2400 |=> ##1 !error_word[mdc_pkg::ERR_LINE_BAUD])
        else $error("2400 baud code flagged as bad");
    digit_order_a:
    assert property (digit_valid_out && digit_ready_in && !sel_q && dial
                     |=> sel_q && idx_q == $past(idx_q) && digit_out == $past(cur_word[7:0]))
        else $error("low byte not sent after high byte");
    ptr_start_a:
    assert property (state_q == mdc_pkg::ST_IDLE && dial_rise && !carrier_in
                     |=> state_q == mdc_pkg::ST_DIGITS && idx_q == $past(ptr_q[3:0]) && !sel_q)
        else $error("dialing did not start at pointed register");
    status_mirror_a:
    assert property (wr_cmd |=> status_word[mdc_pkg::CMD_CFG_HI:1] == $past(bp_wdata_in[mdc_pkg::CMD_CFG_HI:1]))
        else $error("status does not report written configuration");
    window_limit_a:
    assert property (bp_rd_in && bp_addr_in >= mdc_pkg::ADDR_SPARE |=> bp_rdata_out == mdc_pkg::WORD_ZERO)
        else $error("register outside the window read non-zero");
endmodule : mdc_dial_ctrl

// ### src/mdc_pkg.sv
// constants, register map and state codes for the modem dial control block
package mdc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;

    // backplane register indices
    localparam logic [3:0] ADDR_CMD = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_PORT_BAUD = 4'h3;
    localparam logic [3:0] ADDR_LINE_BAUD = 4'h4;
    localparam logic [3:0] ADDR_DIAL_PTR = 4'h5;
    localparam logic [3:0] ADDR_ERROR = 4'h6;
    localparam logic [3:0] ADDR_PASSWORD = 4'h7;
    localparam logic [3:0] ADDR_LAST_PW = 4'h8;
    localparam logic [3:0] ADDR_SPARE = 4'h9;
    localparam logic [3:0] ADDR_DIG_FIRST = 4'hA;
    localparam logic [3:0] ADDR_DIG_LAST = 4'hF;
    localparam int DIGIT_REGS = 6;

    // command and status bit positions
    localparam int CMD_DIAL = 0;
    localparam int CMD_MULTIDROP = 2;
    localparam int CMD_TRANSPARENT = 3;
    localparam int CMD_ORIG_ONLY = 4;
    localparam int CMD_PPAR_LO = 7;
    localparam int CMD_PPAR_HI = 8;
    localparam int CMD_LPAR_LO = 9;
    localparam int CMD_LPAR_HI = 10;
    localparam int CMD_PORT_CRC = 11;
    localparam int CMD_LINE_CRC = 12;
    localparam int CMD_CFG_HI = 13;
    localparam int STAT_CARRIER = 0;
    localparam int STAT_OFF_HOOK = 14;
    localparam int STAT_RING = 15;

    // parity codes and resulting line character length
    localparam logic [1:0] PAR_EVEN = 2'h0;
    localparam logic [1:0] PAR_NONE = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [3:0] CHAR_BITS_NO_PAR = 4'hA;
    localparam logic [3:0] CHAR_BITS_PAR = 4'hB;

    // baud codes and the rates they select
    localparam logic [15:0] BAUD_CODE_1200 = 16'h0007;
    localparam logic [15:0] BAUD_CODE_2400 = 16'h0009;
    localparam logic [15:0] BAUD_CODE_9600 = 16'h000D;
    localparam int unsigned BAUD_1200 = 1200;
    localparam int unsigned BAUD_2400 = 2400;
    localparam int unsigned BAUD_9600 = 9600;

    // error word bits
    localparam int ERR_PORT_BAUD = 0;
    localparam int ERR_LINE_BAUD = 1;
    localparam int ERR_NO_CARRIER = 2;
    localparam int ERR_BAD_PTR = 3;

    // reset values
    localparam logic [15:0] CMD_RST = 16'h1200;
    localparam logic [15:0] BAUD_RST = 16'h000D;
    localparam logic [15:0] PTR_RST = 16'h000A;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // carrier wait after dialing or answering, in seconds
    localparam int unsigned CARRIER_WAIT_S = 60;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DIGITS = 4'h2,
        ST_WAIT = 4'h4,
        ST_ONLINE = 4'h8
    } mdc_state_t;
endpackage : mdc_pkg

// ### src/mdc_baud_tick.sv
// baud code decoder and bit-rate tick generator
`timescale 1ns/1ns
module mdc_baud_tick #(
    parameter int unsigned CLK_HZ = mdc_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // code from register
    input wire logic [15:0] code_in,
    // decoded result
    output logic code_ok_out,
    output logic tick_out
);
    localparam int unsigned DIV_1200 = CLK_HZ / mdc_pkg::BAUD_1200;
    localparam int unsigned DIV_2400 = CLK_HZ / mdc_pkg::BAUD_2400;
    localparam int unsigned DIV_9600 = CLK_HZ / mdc_pkg::BAUD_9600;

    if (DIV_1200 >= 32'h0001_0000 || DIV_9600 < 2) begin : g_bad_clk
        $error("clock rate cannot serve the baud divider");
    end

    logic [15:0] div_sel;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic tick_q;

    // unknown codes stop the tick and flag the error word
    assign div_sel = (code_in == mdc_pkg::BAUD_CODE_9600) ? DIV_9600[15:0] :
                     (code_in == mdc_pkg::BAUD_CODE_2400) ? DIV_2400[15:0] :
                     (code_in == mdc_pkg::BAUD_CODE_1200) ? DIV_1200[15:0] : 16'h0000;
    assign code_ok_out = (div_sel != 16'h0000);
    assign cnt_d = (!code_ok_out || cnt_q >= div_sel - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    assign tick_out = tick_q;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= code_ok_out && (cnt_q == div_sel - 16'h0001);
        end
    end
endmodule : mdc_baud_tick

// ### tb/mdc_plc_model.sv
// rack controller model driving the backplane register window
`timescale 1ns/1ns
module mdc_plc_model (
    // clock
    input wire logic clk_sys_in,
    // backplane window
    output logic [3:0] bp_addr_out,
    output logic bp_wr_out,
    output logic bp_rd_out,
    output logic [15:0] bp_wdata_out,
    input wire logic [15:0] bp_rdata_in
);
    initial begin
        bp_addr_out = 4'h0;
        bp_wr_out = 1'b0;
        bp_rd_out = 1'b0;
        bp_wdata_out = 16'h0000;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_sys_in);
        bp_addr_out = a;
        bp_wdata_out = d;
        bp_wr_out = 1'b1;
        @(negedge clk_sys_in);
        bp_wr_out = 1'b0;
        // released data flips so a stale word never looks valid
        bp_wdata_out = ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge clk_sys_in);
        bp_addr_out = a;
        bp_rd_out = 1'b1;
        @(negedge clk_sys_in);
        bp_rd_out = 1'b0;
        d = bp_rdata_in;
    endtask : rd

    task automatic dial(output logic ok);
        logic [15:0] s;
        logic [15:0] c;
        rd(mdc_pkg::ADDR_STATUS, s);
        ok = ~s[mdc_pkg::STAT_CARRIER];
        if (ok) begin
            rd(mdc_pkg::ADDR_CMD, c);
            wr(mdc_pkg::ADDR_CMD, c | 16'h0001);
        end
    endtask : dial

    task automatic wait_carrier(input int n, output logic up);
        logic [15:0] s;
        up = 1'b0;
        for (int i = 0; i < n && up !== 1'b1; i++) begin
            rd(mdc_pkg::ADDR_STATUS, s);
            up = s[mdc_pkg::STAT_CARRIER];
        end
    endtask : wait_carrier

    task automatic hang();
        logic [15:0] c;
        rd(mdc_pkg::ADDR_CMD, c);
        wr(mdc_pkg::ADDR_CMD, c & 16'hFFFE);
    endtask : hang

    // line check by originator, fast port
    task automatic cfg_link(input logic we_orig, input logic fast_port);
        logic [15:0] c;
        c = 16'h0200;
        if (we_orig) c = c | 16'h1000;
        if (fast_port) c = c | 16'h0880;
        wr(mdc_pkg::ADDR_CMD, c);
    endtask : cfg_link
endmodule : mdc_plc_model

// ### tb/testbench.sv
// self-checking bench for the modem dial control block
`timescale 1ns/1ns
module testbench;
    localparam logic [15:0] RST_VALS [10] = '{16'h0, 16'h1200, 16'h1200, 16'hD, 16'hD, 16'hA, 16'h0, 16'h0, 16'h0, 16'h0};
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [3:0] ba, ca = 4'h0;
    logic bw, br, cw = 1'b0, car = 1'b0, ring = 1'b0, pwv = 1'b0, rdy = 1'b1;
    logic [15:0] bd, rdat, cd = 16'h0, pw = 16'h0, v;
    logic hook, dval, lcrc, pcrc, pt, lt;
    logic [7:0] dig;
    logic [3:0] cbits;
    logic [1:0] lpar, ppar;
    logic [7:0] dq [$];
    int fails = 0;
    int num_checks = 0;

    always #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (dval === 1'b1 && rdy) dq.push_back(dig);

    mdc_plc_model plc (.clk_sys_in(clk_sys_in), .bp_addr_out(ba), .bp_wr_out(bw), .bp_rd_out(br),
        .bp_wdata_out(bd), .bp_rdata_in(rdat));
    mdc_dial_ctrl #(.CARRIER_WAIT_CYC(50)) uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bp_addr_in(ba),
        .bp_wr_in(bw), .bp_rd_in(br), .bp_wdata_in(bd), .bp_rdata_out(rdat), .cfg_addr_in(ca), .cfg_wr_in(cw),
        .cfg_wdata_in(cd), .carrier_in(car), .ring_in(ring), .pw_seen_valid_in(pwv), .pw_seen_in(pw),
        .off_hook_out(hook), .digit_out(dig), .digit_valid_out(dval), .digit_ready_in(rdy),
        .line_char_bits_out(cbits), .line_parity_out(lpar), .line_crc_out(lcrc), .port_parity_out(ppar),
        .port_crc_out(pcrc), .port_tick_out(pt), .line_tick_out(lt));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wait_hook(input logic lvl, input int n);
        repeat (n) begin
            @(negedge clk_sys_in);
            if (hook === lvl) return;
        end
        check("off hook wait", 16'(hook), 16'(lvl));
        give_verdict();
    endtask : wait_hook

    task automatic cfg(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_sys_in);
        ca = a;
        cd = d;
        cw = 1'b1;
        @(negedge clk_sys_in);
        cw = 1'b0;
        cd = ~d;
    endtask : cfg

    // cycles from one tick to the next; zero when no tick shows
    task automatic tick_gap(input logic port, output int gap);
        int t;
        int seen;
        t = 0;
        seen = 0;
        gap = 0;
        while (seen < 2 && t < 20000) begin
            @(negedge clk_sys_in);
            t++;
            if (seen == 1) gap++;
            if ((port ? pt : lt) === 1'b1) seen++;
        end
    endtask : tick_gap

    function automatic logic [15:0] gap_ok(input int g, input int unsigned rate);
        int e;
        e = int'(mdc_pkg::CLK_HZ / rate);
        return 16'(g >= e && g <= e + 1);
    endfunction : gap_ok

    task automatic call(input logic [3:0] ptr, input string ds);
        logic ok;
        plc.wr(mdc_pkg::ADDR_DIAL_PTR, {12'h000, ptr});
        dq.delete();
        plc.dial(ok);
        check("dial taken", 16'(ok), 16'h1);
        wait_hook(1'b1, 4);
        for (int i = 0; i < 40 && dq.size() < ds.len(); i++) @(negedge clk_sys_in);
        repeat (4) @(negedge clk_sys_in);
        check("digit count", 16'(dq.size()), 16'(ds.len()));
        foreach (dq[i]) check("digit", 16'(dq[i]), 16'(ds[i]));
        car = 1'b1;
        plc.wait_carrier(5, ok);
        check("carrier seen", 16'(ok), 16'h1);
    endtask : call

    task automatic t_reset();
        for (int a = 0; a < 10; a++) begin
            plc.rd(a[3:0], v);
            check("reset reg", v, RST_VALS[a]);
        end
        check("char bits", 16'(cbits), 16'hA);
        check("line setup", {13'h0, lpar, lcrc}, 16'h3);
        check("port setup", {13'h0, ppar, pcrc}, 16'h0);
        plc.wr(mdc_pkg::ADDR_DIG_FIRST, 16'h3133);
        plc.rd(mdc_pkg::ADDR_DIG_FIRST, v);
        check("digits hidden", v, 16'h0);
        $display("done reset values");
    endtask : t_reset

    task automatic t_config();
        for (int p = 0; p < 3; p++) begin
            plc.wr(mdc_pkg::ADDR_CMD, 16'h1000 | 16'(p << 9));
            check("char bits", 16'(cbits), (p == 1) ? 16'hA : 16'hB);
            check("line parity", 16'(lpar), 16'(p));
        end
        plc.cfg_link(1'b0, 1'b1);
        check("block check line", 16'(lcrc), 16'h0);
        check("fast port", {13'h0, ppar, pcrc}, 16'h3);
        plc.cfg_link(1'b1, 1'b0);
        check("crc line", {13'h0, lcrc, ppar}, 16'h4);
        plc.rd(mdc_pkg::ADDR_STATUS, v);
        check("status mirror", v, 16'h1200);
        plc.wr(mdc_pkg::ADDR_PASSWORD, 16'h5A5A);
        plc.rd(mdc_pkg::ADDR_PASSWORD, v);
        check("password", v, 16'h5A5A);
        @(negedge clk_sys_in);
        pw = 16'hC3C3;
        pwv = 1'b1;
        @(negedge clk_sys_in);
        pwv = 1'b0;
        plc.rd(mdc_pkg::ADDR_LAST_PW, v);
        check("last password", v, 16'hC3C3);
        $display("done configuration");
    endtask : t_config

    task automatic t_baud();
        int g;
        plc.wr(mdc_pkg::ADDR_LINE_BAUD, mdc_pkg::BAUD_CODE_2400);
        tick_gap(1'b0, g);
        check("line 2400", gap_ok(g, mdc_pkg::BAUD_2400), 16'h1);
        plc.wr(mdc_pkg::ADDR_LINE_BAUD, mdc_pkg::BAUD_CODE_9600);
        tick_gap(1'b0, g);
        check("line 9600", gap_ok(g, mdc_pkg::BAUD_9600), 16'h1);
        tick_gap(1'b1, g);
        check("port 9600", gap_ok(g, mdc_pkg::BAUD_9600), 16'h1);
        plc.wr(mdc_pkg::ADDR_LINE_BAUD, 16'h0005);
        plc.wr(mdc_pkg::ADDR_PORT_BAUD, 16'h0005);
        tick_gap(1'b0, g);
        check("no line tick", 16'(g), 16'h0);
        plc.rd(mdc_pkg::ADDR_ERROR, v);
        check("baud errors", v, 16'h0003);
        plc.wr(mdc_pkg::ADDR_LINE_BAUD, mdc_pkg::BAUD_CODE_9600);
        plc.wr(mdc_pkg::ADDR_PORT_BAUD, mdc_pkg::BAUD_CODE_9600);
        plc.rd(mdc_pkg::ADDR_ERROR, v);
        check("baud ok", v, 16'h0);
        $display("done baud codes");
    endtask : t_baud

    task automatic t_calls();
        logic ok;
        cfg(4'hA, 16'h3133);
        cfg(4'hB, 16'h3536);
        cfg(4'hC, 16'h3700);
        // backplane write must not reach the digit store
        plc.wr(4'hC, 16'h3839);
        call(4'hA, "13567");
        plc.hang();
        wait_hook(1'b0, 4);
        car = 1'b0;
        rdy = 1'b0;
        // dialer stalls before taking the first digit
        fork
            call(4'hB, "567");
            begin
                repeat (12) @(negedge clk_sys_in);
                rdy = 1'b1;
            end
        join
        car = 1'b0;
        wait_hook(1'b0, 4);
        plc.hang();
        car = 1'b1;
        plc.rd(mdc_pkg::ADDR_CMD, v);
        plc.wr(mdc_pkg::ADDR_CMD, v | 16'h0001);
        repeat (5) @(negedge clk_sys_in);
        check("dial with carrier", 16'(hook), 16'h0);
        plc.hang();
        car = 1'b0;
        plc.dial(ok);
        check("dial taken", 16'(ok), 16'h1);
        wait_hook(1'b1, 4);
        wait_hook(1'b0, 120);
        plc.rd(mdc_pkg::ADDR_ERROR, v);
        check("no carrier flag", v, 16'h0004);
        plc.hang();
        plc.wr(mdc_pkg::ADDR_DIAL_PTR, 16'h0005);
        plc.dial(ok);
        check("dial taken", 16'(ok), 16'h1);
        wait_hook(1'b1, 4);
        wait_hook(1'b0, 120);
        plc.rd(mdc_pkg::ADDR_ERROR, v);
        check("bad pointer flag", v, 16'h000C);
        plc.hang();
        $display("done dialed calls");
    endtask : t_calls

    task automatic t_answer();
        ring = 1'b1;
        wait_hook(1'b1, 10);
        ring = 1'b0;
        car = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        check("answered stays", 16'(hook), 16'h1);
        plc.rd(mdc_pkg::ADDR_CMD, v);
        plc.wr(mdc_pkg::ADDR_CMD, v | 16'h0001);
        repeat (3) @(negedge clk_sys_in);
        check("set keeps line", 16'(hook), 16'h1);
        plc.hang();
        wait_hook(1'b0, 4);
        car = 1'b0;
        $display("done answered call");
    endtask : t_answer

    initial begin
        repeat (10) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        t_reset();
        t_config();
        t_baud();
        t_calls();
        t_answer();
        give_verdict();
    end
endmodule : testbench
